// *** rtl/cms_top.sv ***
// control mode select, strap decode, parallel register port and interrupt pin
// assumes host pins synchronous to clk; straps held static in operation
`timescale 1ns/10ps
module cms_top import cms_pkg::*; (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [1:0] mode_select,
    input wire logic rx_edge_select,
    input wire logic [1:0] rail_coding_select,
    input wire logic [1:0] ch1_loopback_select,
    input wire logic cs_n,
    input wire logic [5:0] addr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire logic data_or_read_strobe_n,
    input wire logic dir_or_write_strobe_n,
    input wire logic [15:0] int_source,
    output logic int_out,
    output logic int_oe,
    output cms_ctrl_e ctrl_mode,
    output cms_cfg_s ch1_cfg
);
    // ********************************
    // strap synchronisation
    // ********************************
    cms_strap_s strap_raw;
    cms_strap_s strap;
    assign strap_raw = '{mode: mode_select, rx_edge: rx_edge_select,
                         rail_coding: rail_coding_select, loopback: ch1_loopback_select};

    cms_sync #(.W($bits(cms_strap_s))) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .d(strap_raw),
        .q(strap)
    );

    logic hw_mode;
    logic par_mode;
    assign hw_mode = (cms_ctrl_e'(strap.mode) == CMS_CTRL_HW);
    assign par_mode = strap.mode[1];

    // ********************************
    // parallel port strobes
    // ********************************
    logic port_sel;
    logic rd_act;
    logic wr_act;
    assign port_sel = par_mode && !cs_n;
    always_comb begin
        rd_act = 1'b0;
        wr_act = 1'b0;
        if (port_sel) begin
            if (!strap.mode[0]) begin
                // strobe plus direction
                rd_act = !data_or_read_strobe_n && dir_or_write_strobe_n;
                wr_act = !data_or_read_strobe_n && !dir_or_write_strobe_n;
            end else begin
                rd_act = !data_or_read_strobe_n;
                wr_act = !dir_or_write_strobe_n && data_or_read_strobe_n;
            end
        end
    end

    // ********************************
    // registers
    // ********************************
    logic rd_act_r, rd_act_nxt;
    logic wr_act_r, wr_act_nxt;
    logic [5:0] rd_addr_r, rd_addr_nxt;
    logic [7:0] mask_lo_r, mask_lo_nxt;
    logic [7:0] mask_hi_r, mask_hi_nxt;
    logic [7:0] stat_lo_r, stat_lo_nxt;
    logic [7:0] stat_hi_r, stat_hi_nxt;
    logic [7:0] int_ctrl_r, int_ctrl_nxt;
    logic [7:0] sw_cfg_r, sw_cfg_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic wr_take;
    logic rd_done;
    logic [15:0] clr;

    assign wr_take = wr_act && !wr_act_r;
    // clear on the trailing edge so the host sees the value it read
    assign rd_done = rd_act_r && !rd_act;

    always_comb begin
        rd_act_nxt = rd_act;
        wr_act_nxt = wr_act;
        rd_addr_nxt = (rd_act && !rd_act_r) ? addr : rd_addr_r;
        mask_lo_nxt = mask_lo_r;
        mask_hi_nxt = mask_hi_r;
        int_ctrl_nxt = int_ctrl_r;
        sw_cfg_nxt = sw_cfg_r;
        clr = 16'h0000;
        if (wr_take) begin
            unique case (addr)
                CMS_ADDR_MASK_LO: mask_lo_nxt = data_in;
                CMS_ADDR_MASK_HI: mask_hi_nxt = data_in;
                CMS_ADDR_INT_CTRL: int_ctrl_nxt = data_in;
                CMS_ADDR_SW_CFG: sw_cfg_nxt = data_in;
                default: ;
            endcase
        end
        if (rd_done && rd_addr_r == CMS_ADDR_STAT_LO) begin
            clr[7:0] = 8'hFF;
        end
        if (rd_done && rd_addr_r == CMS_ADDR_STAT_HI) begin
            clr[15:8] = 8'hFF;
        end
        // a new event beats the read clear
        {stat_hi_nxt, stat_lo_nxt} = ({stat_hi_r, stat_lo_r} & ~clr) | int_source;
        unique case (addr)
            CMS_ADDR_MASK_LO: rdata_nxt = mask_lo_r;
            CMS_ADDR_MASK_HI: rdata_nxt = mask_hi_r;
            CMS_ADDR_STAT_LO: rdata_nxt = stat_lo_r;
            CMS_ADDR_STAT_HI: rdata_nxt = stat_hi_r;
            CMS_ADDR_INT_CTRL: rdata_nxt = int_ctrl_r;
            CMS_ADDR_SW_CFG: rdata_nxt = sw_cfg_r;
            default: rdata_nxt = CMS_UNMAPPED_DATA;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_act_r <= 1'b0;
            wr_act_r <= 1'b0;
            rd_addr_r <= 6'h00;
            mask_lo_r <= CMS_MASK_RST;
            mask_hi_r <= CMS_MASK_RST;
            stat_lo_r <= CMS_STAT_RST;
            stat_hi_r <= CMS_STAT_RST;
            int_ctrl_r <= CMS_INT_CTRL_RST;
            sw_cfg_r <= CMS_SW_CFG_RST;
            rdata_r <= 8'h00;
        end else begin
            rd_act_r <= rd_act_nxt;
            wr_act_r <= wr_act_nxt;
            rd_addr_r <= rd_addr_nxt;
            mask_lo_r <= mask_lo_nxt;
            mask_hi_r <= mask_hi_nxt;
            stat_lo_r <= stat_lo_nxt;
            stat_hi_r <= stat_hi_nxt;
            int_ctrl_r <= int_ctrl_nxt;
            sw_cfg_r <= sw_cfg_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign data_out = rdata_r;
    assign data_oe = rd_act;

    // ********************************
    // decoded configuration and interrupt pin
    // ********************************
    cms_cfg_s cfg_r, cfg_nxt;
    logic int_req_r, int_req_nxt;
    logic [1:0] rc_sel;
    logic [1:0] lb_sel;

    always_comb begin
        rc_sel = hw_mode ? strap.rail_coding : sw_cfg_r[CMS_SC_RC_LSB +: 2];
        lb_sel = hw_mode ? strap.loopback : sw_cfg_r[CMS_SC_LB_LSB +: 2];
        cfg_nxt.rx_on_falling = hw_mode ? strap.rx_edge : sw_cfg_r[CMS_SC_RX_FALL];
        cfg_nxt.single_rail = !rc_sel[1];
        cfg_nxt.coding_ami = (cms_rc_e'(rc_sel) == CMS_RC_SR_AMI);
        cfg_nxt.clock_data_recovery = (cms_rc_e'(rc_sel) != CMS_RC_SLICER);
        cfg_nxt.loopback = cms_lb_e'(lb_sel);
        cfg_nxt.inband_enable = !hw_mode && sw_cfg_r[CMS_SC_INBAND];
        int_req_nxt = |({stat_hi_r, stat_lo_r} & ~{mask_hi_r, mask_lo_r})
                      && !int_ctrl_r[CMS_IC_GLOBAL_MASK];
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_r <= '{rx_on_falling: 1'b0, single_rail: 1'b1, coding_ami: 1'b0,
                       clock_data_recovery: 1'b1, loopback: CMS_LB_NONE, inband_enable: 1'b0};
            int_req_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            int_req_r <= int_req_nxt;
        end
    end

    assign ch1_cfg = cfg_r;
    assign ctrl_mode = cms_ctrl_e'(strap.mode);
    // open drain pulls low when asserted and floats otherwise
    assign int_oe = int_ctrl_r[CMS_IC_PUSH_PULL] || int_req_r;
    assign int_out = int_ctrl_r[CMS_IC_PUSH_PULL] ?
                     (int_req_r == int_ctrl_r[CMS_IC_ACTIVE_HIGH]) : 1'b0;

    // ********************************
    // assertions
    // ********************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    port_mode_a: assert property (data_oe |-> par_mode && !cs_n)
        else $error("data driven outside parallel mode");
    cs_ignore_a: assert property (cs_n |=> $stable(mask_lo_r) && $stable(mask_hi_r))
        else $error("mask changed while deselected");
    rx_edge_a: assert property (hw_mode && $stable(strap) |=> cfg_r.rx_on_falling == $past(strap.rx_edge))
        else $error("receive edge not from strap");
    rail_single_a: assert property (hw_mode && strap.rail_coding == 2'h1
                                    |=> cfg_r.single_rail && cfg_r.coding_ami)
        else $error("ami single rail not decoded");
    slicer_mode_a: assert property (hw_mode && strap.rail_coding == 2'h3
                                    |=> !cfg_r.single_rail && !cfg_r.clock_data_recovery)
        else $error("slicer mode not decoded");
    lb_digital_a: assert property (hw_mode && strap.loopback == 2'h2 |=> cfg_r.loopback == CMS_LB_DIGITAL)
        else $error("digital loopback not decoded");
    lb_analog_a: assert property (hw_mode && strap.loopback == 2'h1 |=> cfg_r.loopback == CMS_LB_ANALOG)
        else $error("analog loopback not decoded");
    no_inband_a: assert property (hw_mode |=> !cfg_r.inband_enable)
        else $error("inband loopback in hardware mode");
    global_mask_a: assert property (int_ctrl_r[CMS_IC_GLOBAL_MASK] |=> !int_req_r)
        else $error("request despite global mask");
    src_mask_a: assert property (int_source[0] && !mask_lo_r[0] && !int_ctrl_r[CMS_IC_GLOBAL_MASK]
                                 ##1 !mask_lo_r[0] && !int_ctrl_r[CMS_IC_GLOBAL_MASK] |=> int_req_r)
        else $error("unmasked source gave no request");
    stat_set_a: assert property (int_source[8] |=> stat_hi_r[0])
        else $error("status bit not set by source");
    pp_drive_a: assert property (int_ctrl_r[CMS_IC_PUSH_PULL]
                                 |-> int_oe && int_out == (int_req_r == int_ctrl_r[CMS_IC_ACTIVE_HIGH]))
        else $error("push-pull pin wrong");

    hw_mode_c: cover property (hw_mode ##1 cfg_r.loopback == CMS_LB_REMOTE);
    par_write_c: cover property (wr_take && addr == CMS_ADDR_MASK_LO);
    stat_read_c: cover property (rd_done && rd_addr_r == CMS_ADDR_STAT_LO);
    int_fire_c: cover property (!int_req_r ##1 int_req_r);
endmodule

// *** rtl/cms_pkg.sv ***
// constants, types and register map of the control mode and strap decode block
// assumes one 50 MHz clock and synchronous active-high reset
package cms_pkg;

    // ********************************
    // register map
    // ********************************
    localparam logic [5:0] CMS_ADDR_MASK_LO = 6'h13;
    localparam logic [5:0] CMS_ADDR_MASK_HI = 6'h14;
    localparam logic [5:0] CMS_ADDR_STAT_LO = 6'h18;
    localparam logic [5:0] CMS_ADDR_STAT_HI = 6'h19;
    localparam logic [5:0] CMS_ADDR_INT_CTRL = 6'h3E;
    localparam logic [5:0] CMS_ADDR_SW_CFG = 6'h3F;

    localparam logic [7:0] CMS_MASK_RST = 8'hFF;
    localparam logic [7:0] CMS_STAT_RST = 8'h00;
    localparam logic [7:0] CMS_INT_CTRL_RST = 8'h01;
    localparam logic [7:0] CMS_SW_CFG_RST = 8'h00;
    localparam logic [7:0] CMS_UNMAPPED_DATA = 8'h00;

    // interrupt control fields
    localparam int CMS_IC_GLOBAL_MASK = 0;
    localparam int CMS_IC_PUSH_PULL = 1;
    localparam int CMS_IC_ACTIVE_HIGH = 2;

    // software config fields
    localparam int CMS_SC_LB_LSB = 0;
    localparam int CMS_SC_INBAND = 2;
    localparam int CMS_SC_RX_FALL = 3;
    localparam int CMS_SC_RC_LSB = 4;

    localparam int CMS_SYNC_STAGES = 2;

    // ********************************
    // types
    // ********************************
    typedef enum logic [1:0] {
        CMS_CTRL_HW = 2'h0,
        CMS_CTRL_SERIAL = 2'h1,
        CMS_CTRL_PAR_DS = 2'h2,
        CMS_CTRL_PAR_RW = 2'h3
    } cms_ctrl_e;

    typedef enum logic [1:0] {
        CMS_LB_NONE = 2'h0,
        CMS_LB_ANALOG = 2'h1,
        CMS_LB_DIGITAL = 2'h2,
        CMS_LB_REMOTE = 2'h3
    } cms_lb_e;

    typedef enum logic [1:0] {
        CMS_RC_SR_HDB3 = 2'h0,
        CMS_RC_SR_AMI = 2'h1,
        CMS_RC_DR_RECOVERY = 2'h2,
        CMS_RC_SLICER = 2'h3
    } cms_rc_e;

    typedef struct packed {
        logic [1:0] mode;
        logic rx_edge;
        logic [1:0] rail_coding;
        logic [1:0] loopback;
    } cms_strap_s;

    typedef struct packed {
        logic rx_on_falling;
        logic single_rail;
        logic coding_ami;
        logic clock_data_recovery;
        cms_lb_e loopback;
        logic inband_enable;
    } cms_cfg_s;

endpackage

// *** rtl/cms_sync.sv ***
// two-flop synchroniser for quasi-static strap levels
// assumes inputs change rarely; no multi-bit coherence is needed
`timescale 1ns/10ps
module cms_sync import cms_pkg::*; #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;
endmodule

// *** testbench/cms_host.sv ***
// host microcontroller model on the parallel register port
// assumes one access at a time, called from clk-aligned bench code
`timescale 1ns/10ps
module cms_host import cms_pkg::*; (
    input wire logic clk,
    input wire logic [1:0] mode,
    input wire logic [7:0] rd_bus,
    output logic cs_n,
    output logic [5:0] addr,
    output logic [7:0] wd,
    output logic s1_n,
    output logic s2_n
);
    initial begin
        cs_n = 1'b1;
        addr = 6'h00;
        wd = 8'h00;
        s1_n = 1'b1;
        s2_n = 1'b1;
    end

    // released lines show the inverse, never a stale copy
    task automatic idle();
        cs_n <= 1'b1;
        s1_n <= 1'b1;
        s2_n <= 1'b1;
        addr <= ~addr;
        wd <= ~wd;
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic sel_n);
        @(posedge clk);
        cs_n <= sel_n;
        addr <= a;
        wd <= d;
        s1_n <= mode[0];
        s2_n <= 1'b0;
        @(posedge clk);
        idle();
        @(posedge clk);
    endtask

    task automatic rd(input logic [5:0] a, output logic [7:0] v);
        @(posedge clk);
        cs_n <= 1'b0;
        addr <= a;
        s1_n <= 1'b0;
        s2_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1 v = rd_bus;
        @(posedge clk);
        idle();
        @(posedge clk);
    endtask
endmodule

// *** testbench/cms_top_tb.sv ***
// self-checking bench for the control mode and strap decode block
// assumes the host model in cms_host.sv; the interrupt pin has a pull-up
`timescale 1ns/10ps
module cms_top_tb import cms_pkg::*; ;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [1:0] mode_select = 2'h3;
    logic rx_edge_select = 1'b0;
    logic [1:0] rail_coding_select = 2'h0;
    logic [1:0] ch1_loopback_select = 2'h0;
    logic [15:0] src = 16'h0000;
    logic cs_n, s1_n, s2_n, data_oe, int_out, int_oe;
    logic [5:0] addr;
    logic [7:0] h_wd, data_out, d_bus, got_v;
    logic [7:0] exp_q[$];
    cms_ctrl_e ctrl_mode;
    cms_cfg_s ch1_cfg, ec;
    event got_e;
    int n_fail = 0;
    int cmp_count = 0;

    assign d_bus = data_oe ? data_out : h_wd;

    cms_host i_host (.clk(clk), .mode(mode_select), .rd_bus(d_bus), .cs_n(cs_n), .addr(addr),
        .wd(h_wd), .s1_n(s1_n), .s2_n(s2_n));

    cms_top i_dut (.clk(clk), .sys_rst(sys_rst), .mode_select(mode_select),
        .rx_edge_select(rx_edge_select), .rail_coding_select(rail_coding_select),
        .ch1_loopback_select(ch1_loopback_select), .cs_n(cs_n), .addr(addr), .data_in(d_bus),
        .data_out(data_out), .data_oe(data_oe), .data_or_read_strobe_n(s1_n),
        .dir_or_write_strobe_n(s2_n), .int_source(src), .int_out(int_out), .int_oe(int_oe),
        .ctrl_mode(ctrl_mode), .ch1_cfg(ch1_cfg));

    initial begin
        forever #10 clk = ~clk;
    end

    task automatic close_out();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ********************************
    // result watcher
    // ********************************
    initial begin
        forever begin
            @(got_e);
            cmp_count++;
            if (exp_q.size() == 0 || exp_q[0] !== got_v) begin
                $display("mismatch at %0t: got %h", $time, got_v);
                n_fail++;
            end
            if (exp_q.size() > 0) begin
                void'(exp_q.pop_front());
            end
        end
    end

    task automatic chk(input logic [7:0] e, input logic [7:0] v);
        exp_q.push_back(e);
        got_v = v;
        ->got_e;
        #1;
    endtask

    task automatic rdc(input logic [5:0] a, input logic [7:0] e);
        logic [7:0] v;
        i_host.rd(a, v);
        chk(e, v);
    endtask

    // pin level with the pull-up applied, plus the enable
    // one more edge so a request launched by the last write has settled
    task automatic pin_chk(input logic [1:0] e);
        @(posedge clk);
        #1 chk({6'h00, e}, {6'h00, int_oe, int_oe ? int_out : 1'b1});
    endtask

    task automatic set_mode(input logic [1:0] m);
        @(posedge clk);
        mode_select <= m;
        repeat (4) @(posedge clk);
        #1 chk({6'h00, m}, {6'h00, ctrl_mode});
    endtask

    task automatic pulse(input int i);
        @(posedge clk);
        src[i] <= 1'b1;
        @(posedge clk);
        src <= 16'h0000;
        repeat (4) @(posedge clk);
        #1;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        close_out();
    end

    // ********************************
    // main sequence
    // ********************************
    initial begin
        logic [7:0] d, d2;
        int b, c;
        void'($urandom(65376));
        d = 8'($urandom);
        d2 = 8'($urandom);
        b = $urandom % 8;
        c = $urandom % 8;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        set_mode(2'h3);
        rdc(CMS_ADDR_MASK_LO, 8'hFF);
        rdc(CMS_ADDR_MASK_HI, 8'hFF);
        rdc(CMS_ADDR_STAT_LO, 8'h00);
        rdc(CMS_ADDR_STAT_HI, 8'h00);
        rdc(6'h20, 8'h00);
        rdc(CMS_ADDR_INT_CTRL, 8'h01);
        i_host.wr(CMS_ADDR_MASK_LO, d, 1'b0);
        rdc(CMS_ADDR_MASK_LO, d);
        i_host.wr(CMS_ADDR_MASK_LO, ~d, 1'b1);
        rdc(CMS_ADDR_MASK_LO, d);
        i_host.wr(CMS_ADDR_STAT_LO, 8'hFF, 1'b0);
        rdc(CMS_ADDR_STAT_LO, 8'h00);
        set_mode(2'h2);
        i_host.wr(CMS_ADDR_MASK_HI, d2, 1'b0);
        rdc(CMS_ADDR_MASK_HI, d2);
        set_mode(2'h1);
        i_host.wr(CMS_ADDR_MASK_HI, ~d2, 1'b0);
        set_mode(2'h0);
        i_host.wr(CMS_ADDR_MASK_HI, ~d2, 1'b0);
        set_mode(2'h2);
        rdc(CMS_ADDR_MASK_HI, d2);
        i_host.wr(CMS_ADDR_MASK_HI, 8'hFF, 1'b0);
        i_host.wr(CMS_ADDR_MASK_LO, 8'hFF, 1'b0);
        pulse(b);
        pin_chk(2'h1);
        i_host.wr(CMS_ADDR_INT_CTRL, 8'h00, 1'b0);
        pin_chk(2'h1);
        i_host.wr(CMS_ADDR_MASK_LO, 8'h00, 1'b0);
        pin_chk(2'h2);
        i_host.wr(CMS_ADDR_INT_CTRL, 8'h06, 1'b0);
        pin_chk(2'h3);
        i_host.wr(CMS_ADDR_INT_CTRL, 8'h02, 1'b0);
        pin_chk(2'h2);
        i_host.wr(CMS_ADDR_INT_CTRL, 8'h00, 1'b0);
        rdc(CMS_ADDR_STAT_LO, 8'h01 << b);
        rdc(CMS_ADDR_STAT_LO, 8'h00);
        pin_chk(2'h1);
        pulse(8 + c);
        pin_chk(2'h1);
        rdc(CMS_ADDR_STAT_HI, 8'h01 << c);
        pulse(0);
        pin_chk(2'h2);
        rdc(CMS_ADDR_STAT_LO, 8'h01);
        pulse(8);
        rdc(CMS_ADDR_STAT_HI, 8'h01);
        // software config: digital loopback, inband on, falling edge, dual rail with recovery
        i_host.wr(CMS_ADDR_SW_CFG, 8'h2E, 1'b0);
        repeat (3) @(posedge clk);
        #1 chk(8'h4D, {1'b0, ch1_cfg});
        set_mode(2'h0);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            rail_coding_select <= 2'(i / 4);
            ch1_loopback_select <= 2'(i % 4);
            rx_edge_select <= 1'($urandom);
            repeat (5) @(posedge clk);
            #1;
            ec.rx_on_falling = rx_edge_select;
            ec.single_rail = ~rail_coding_select[1];
            ec.coding_ami = (rail_coding_select == 2'h1);
            ec.clock_data_recovery = (rail_coding_select != 2'h3);
            ec.loopback = cms_lb_e'(ch1_loopback_select);
            ec.inband_enable = 1'b0;
            chk({1'b0, ec}, {1'b0, ch1_cfg});
        end
        close_out();
    end
endmodule
